// File: cbf_breaker_model.sv
// Behavioural model of the redundant trip coil and breaker seen by the block
`default_nettype none
module cbf_breaker_model #(
  parameter int unsigned P_OP_CYCLES = 4
) (
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  input  wire logic i_stuck,
  input  wire logic i_retrip,
  output logic      o_open
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  // Opens P_OP_CYCLES cycles after retrip rises unless i_stuck is high, well inside the failure delay; with retrip off or i_stuck high it never opens
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) cnt <= 0;
    else if (!i_retrip || i_stuck) cnt <= 0;
    else if (cnt < P_OP_CYCLES) cnt <= cnt + 1;
  end
  assign o_open = (cnt == P_OP_CYCLES);
endmodule
`default_nettype wire

// File: cbf_pick_if.sv
// Interface between the control core and the pick-up comparators
`default_nettype none
interface cbf_pick_if;
  logic                              tick;
  logic                              res_en;
  logic [3:0][cbf_pkg::MAG_W-1:0]    mag;
  logic [cbf_pkg::MAG_W-1:0]         thr_ph;
  logic [cbf_pkg::MAG_W-1:0]         thr_res;
  logic [3:0]                        pick;
  modport ctl (output tick, res_en, mag, thr_ph, thr_res, input pick);
  modport cmp (input tick, res_en, mag, thr_ph, thr_res, output pick);
endinterface
`default_nettype wire

// File: cbf_pickup.sv
// Pick-up comparators with release hysteresis, one per measured channel
`default_nettype none
module cbf_pickup (
  input  wire logic   i_mclk,
  input  wire logic   i_nrst,
  cbf_pick_if.cmp     pif
);
  typedef struct packed {
    logic [3:0] pick;
  } cbf_pk_s;

  cbf_pk_s st_reg;
  cbf_pk_s st_next;

  // Hold while at or above 97 percent, pick only when strictly above
  function automatic logic pick_eval(input logic                      cur,
                                     input logic [cbf_pkg::MAG_W-1:0] mag,
                                     input logic [cbf_pkg::MAG_W-1:0] thr);
    logic [23:0] scaled_mag;
    logic [23:0] scaled_thr;
    scaled_mag = 24'(mag) * 24'(cbf_pkg::FULL_PCT);
    scaled_thr = 24'(thr) * 24'(cbf_pkg::RELEASE_PCT);
    if (cur) begin
      pick_eval = (scaled_mag >= scaled_thr); // [R2]
    end else begin
      pick_eval = (mag > thr); // [R3] [R4]
    end
  endfunction

  always_comb begin
    st_next = st_reg;
    if (pif.tick) begin
      for (int k = 0; k < 3; k++) begin
        st_next.pick[k] = pick_eval(st_reg.pick[k], pif.mag[k], pif.thr_ph); // [R1] [R3]
      end
      st_next.pick[3] = pif.res_en && pick_eval(st_reg.pick[3], pif.mag[3], pif.thr_res); // [R1] [R5]
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pif.pick = st_reg.pick;

  a_hyst_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R2]
    pif.tick && pif.pick[0] &&
    (24'(pif.mag[0]) * 24'(cbf_pkg::FULL_PCT) >= 24'(pif.thr_ph) * 24'(cbf_pkg::RELEASE_PCT))
    |=> pif.pick[0])
    else $error("phase pick-up released above the hysteresis level");

  a_res_unused: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R5]
    pif.tick && !pif.res_en |=> !pif.pick[3])
    else $error("residual picked up while not in use");
endmodule
`default_nettype wire

// File: cbf_pkg.sv
// Constants, types and register map of the breaker-failure protection block
// How it works
// [R1] Every program cycle compare three phase and the selected residual magnitudes to thresholds.
// [R2] A picked channel releases only below 97 percent of its threshold.
// [R3] One phase threshold serves all phases; any phase above it picks up.
// [R4] Nothing happens while all magnitudes stay at or below threshold.
// [R5] Residual source: not in use (default), input one, input two, calculated.
// [R6] Eleven operating modes join current, signals and relays by AND or OR.
// [R7] Phase threshold counts in 0.01 In steps, reset value 0.20 In.
// [R8] Residual threshold counts in 0.001 In steps, reset value 1.200 In.
// [R9] Blocking input is sampled at the start of every program cycle.
// [R10] Pick-up without blocking raises start and runs the delay timer.
// [R11] Pick-up under blocking raises blocked and does nothing else.
// [R12] Blocking during start clears start as if pick-up dropped out.
// [R13] Blocking must arrive 5 ms before the delay elapses.
// [R14] Retrip and failure timers start from the same pick-up.
// [R15] Failure delay should exceed retrip delay plus breaker and release times.
// [R16] Retrip enable, default on; when off, no retrip output.
// [R17] Retrip after the start persists for the retrip delay, 5 ms steps, 0.100 s.
// [R18] Failure output after the start persists for its delay, default 0.200 s.
// [R19] Readable condition: normal, start, retrip, failure, on, blocked.
// [R20] Readable behaviour: on, blocked, test, test blocked, off.
// [R21] Settings may change while the function runs.
// [R22] Masked trip events and masked output relays may start the countdown.
// [R23] In current-only mode timers reset once all currents fall below threshold.
// [R24] In current and relay mode timers hold until the relay is driven.
// [R25] In current or relay mode either criterion keeps counting.
// [R26] Timers count one step per 5 ms program-cycle tick.
`default_nettype none
package cbf_pkg;
  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned STEP_MS     = 5;
  localparam int unsigned TICK_CYCLES = CLK_MHZ * STEP_MS * 1000;
  localparam int unsigned MAG_W       = 16;
  localparam int unsigned DLY_W       = 19;
  localparam int unsigned RETRIP_DELAY_MS = 100;
  localparam int unsigned FAIL_DELAY_MS   = 200;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_PH_THR  = 8'h04;
  localparam logic [7:0] A_RES_THR = 8'h08;
  localparam logic [7:0] A_RT_DLY  = 8'h0C;
  localparam logic [7:0] A_BF_DLY  = 8'h10;
  localparam logic [7:0] A_SIG_MSK = 8'h14;
  localparam logic [7:0] A_DO_MSK  = 8'h18;
  localparam logic [7:0] A_STATUS  = 8'h1C;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_RES_LSB  = 4;
  localparam int unsigned CTRL_RT_BIT   = 6;
  localparam int unsigned CTRL_LN_LSB   = 8;
  localparam int unsigned ST_COND_LSB   = 0;
  localparam int unsigned ST_LN_LSB     = 4;
  localparam int unsigned ST_START_BIT  = 8;
  localparam int unsigned ST_BLK_BIT    = 9;
  localparam int unsigned ST_RT_BIT     = 10;
  localparam int unsigned ST_BF_BIT     = 11;
  localparam int unsigned ST_PICK_LSB   = 12;

  localparam logic [MAG_W-1:0] PH_THR_RST  = 16'h0014;
  localparam logic [MAG_W-1:0] RES_THR_RST = 16'h04B0;
  localparam logic [DLY_W-1:0] RT_DLY_RST  = DLY_W'(RETRIP_DELAY_MS / STEP_MS);
  localparam logic [DLY_W-1:0] BF_DLY_RST  = DLY_W'(FAIL_DELAY_MS / STEP_MS);
  localparam logic [7:0]       RELEASE_PCT = 8'h61;
  localparam logic [7:0]       FULL_PCT    = 8'h64;

  typedef enum logic [3:0] {
    CBF_M_CUR        = 4'h0,
    CBF_M_DO         = 4'h1,
    CBF_M_SIG        = 4'h2,
    CBF_M_CUR_AND_DO = 4'h3,
    CBF_M_CUR_OR_DO  = 4'h4,
    CBF_M_CUR_OR_SIG = 4'h5,
    CBF_M_CUR_AND_SIG = 4'h6,
    CBF_M_SIG_AND_DO = 4'h7,
    CBF_M_SIG_OR_DO  = 4'h8,
    CBF_M_ANY        = 4'h9,
    CBF_M_ALL        = 4'hA
  } cbf_mode_e;

  typedef enum logic [1:0] {
    CBF_R_NONE = 2'h0,
    CBF_R_ONE  = 2'h1,
    CBF_R_TWO  = 2'h2,
    CBF_R_CALC = 2'h3
  } cbf_res_e;

  typedef enum logic [2:0] {
    CBF_LN_ON      = 3'h0,
    CBF_LN_BLOCKED = 3'h1,
    CBF_LN_TEST    = 3'h2,
    CBF_LN_TEST_BLK = 3'h3,
    CBF_LN_OFF     = 3'h4
  } cbf_ln_e;

  typedef enum logic [2:0] {
    CBF_C_NORMAL  = 3'h0,
    CBF_C_START   = 3'h1,
    CBF_C_RETRIP  = 3'h2,
    CBF_C_FAIL    = 3'h3,
    CBF_C_ON      = 3'h4,
    CBF_C_BLOCKED = 3'h5
  } cbf_cond_e;
endpackage
`default_nettype wire

// File: cbf_top.sv
// Breaker-failure protection core: settings, pick-up logic, timers, outputs
//
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
module cbf_top #(
  parameter int unsigned P_TICK_CYCLES = cbf_pkg::TICK_CYCLES,
  parameter int unsigned P_N_SIG       = 16,
  parameter int unsigned P_N_DO        = 8
) (
  input  wire logic                                 i_mclk,
  input  wire logic                                 i_nrst,
  input  wire logic [7:0]                           i_addr,
  input  wire logic [31:0]                          i_wdata,
  input  wire logic                                 i_wr,
  input  wire logic                                 i_rd,
  output logic      [31:0]                          o_rdata,
  input  wire logic [2:0][cbf_pkg::MAG_W-1:0]       i_measured_magnitude,
  input  wire logic [cbf_pkg::MAG_W-1:0]            i_residual_input_one,
  input  wire logic [cbf_pkg::MAG_W-1:0]            i_residual_input_two,
  input  wire logic [cbf_pkg::MAG_W-1:0]            i_calculated_residual,
  input  wire logic                                 i_block,
  input  wire logic [P_N_SIG-1:0]                   i_trip_events,
  input  wire logic [P_N_DO-1:0]                    i_relay_state,
  output logic                                      o_start,
  output logic                                      o_blocked,
  output logic                                      o_retrip,
  output logic                                      o_breaker_failure_output
);
  localparam int unsigned TW = $clog2(P_TICK_CYCLES);
  localparam logic [TW-1:0] DIV_LAST = TW'(P_TICK_CYCLES - 1);
  localparam int unsigned MW = cbf_pkg::MAG_W;
  localparam int unsigned DW = cbf_pkg::DLY_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TW-1:0]      div;
    logic               tick;
    logic               eval;
    logic               blk_s;
    cbf_pkg::cbf_mode_e mode;
    cbf_pkg::cbf_res_e  res_sel;
    logic               rt_en;
    cbf_pkg::cbf_ln_e   ln;
    logic [MW-1:0]      ph_thr;
    logic [MW-1:0]      res_thr;
    logic [DW-1:0]      rt_dly;
    logic [DW-1:0]      bf_dly;
    logic [P_N_SIG-1:0] sig_mask;
    logic [P_N_DO-1:0]  do_mask;
    logic [DW-1:0]      elapsed;
    logic               start;
    logic               blocked;
    logic               retrip;
    logic               fail;
    cbf_pkg::cbf_cond_e cond;
    logic [31:0]        rdata;
  } cbf_st_s;

  cbf_st_s st_reg;
  cbf_st_s st_next;

  cbf_pick_if pif ();

  logic cur_hit;
  logic sig_hit;
  logic do_hit;
  logic crit;

  // ----------------------------------------------------------------
  // Mode combination
  // ----------------------------------------------------------------
  function automatic logic mode_crit(input cbf_pkg::cbf_mode_e m,
                                     input logic c,
                                     input logic s,
                                     input logic d);
    case (m)
      cbf_pkg::CBF_M_CUR:         mode_crit = c;
      cbf_pkg::CBF_M_DO:          mode_crit = d;
      cbf_pkg::CBF_M_SIG:         mode_crit = s;
      cbf_pkg::CBF_M_CUR_AND_DO:  mode_crit = c & d;
      cbf_pkg::CBF_M_CUR_OR_DO:   mode_crit = c | d;
      cbf_pkg::CBF_M_CUR_OR_SIG:  mode_crit = c | s;
      cbf_pkg::CBF_M_CUR_AND_SIG: mode_crit = c & s;
      cbf_pkg::CBF_M_SIG_AND_DO:  mode_crit = s & d;
      cbf_pkg::CBF_M_SIG_OR_DO:   mode_crit = s | d;
      cbf_pkg::CBF_M_ANY:         mode_crit = c | s | d;
      cbf_pkg::CBF_M_ALL:         mode_crit = c & s & d;
      default:                    mode_crit = c;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Comparator hookup
  // ----------------------------------------------------------------
  assign pif.tick    = st_reg.tick;
  assign pif.res_en  = (st_reg.res_sel != cbf_pkg::CBF_R_NONE);
  assign pif.thr_ph  = st_reg.ph_thr;
  assign pif.thr_res = st_reg.res_thr;

  always_comb begin
    pif.mag[2:0] = i_measured_magnitude;
    case (st_reg.res_sel)
      cbf_pkg::CBF_R_ONE:  pif.mag[3] = i_residual_input_one;
      cbf_pkg::CBF_R_TWO:  pif.mag[3] = i_residual_input_two;
      cbf_pkg::CBF_R_CALC: pif.mag[3] = i_calculated_residual;
      default:             pif.mag[3] = '0;
    endcase
  end

  cbf_pickup u_pickup (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .pif    (pif.cmp)
  );

  assign cur_hit = |pif.pick;
  assign sig_hit = |(i_trip_events & st_reg.sig_mask); // [R22]
  assign do_hit  = |(i_relay_state & st_reg.do_mask); // [R22]
  assign crit    = mode_crit(st_reg.mode, cur_hit, sig_hit, do_hit); // [R6] [R24] [R25]

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Constant, so the asynchronous reset branch loads no logic
  localparam cbf_st_s ST_RST = '{
    mode:    cbf_pkg::CBF_M_CUR, // [R6]
    res_sel: cbf_pkg::CBF_R_NONE, // [R5]
    rt_en:   1'b1, // [R16]
    ln:      cbf_pkg::CBF_LN_ON,
    ph_thr:  cbf_pkg::PH_THR_RST, // [R7]
    res_thr: cbf_pkg::RES_THR_RST, // [R8]
    rt_dly:  cbf_pkg::RT_DLY_RST, // [R17]
    bf_dly:  cbf_pkg::BF_DLY_RST, // [R18]
    cond:    cbf_pkg::CBF_C_NORMAL,
    default: '0
  };

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic           off;
    logic           test;
    logic [DW-1:0]  el;
    logic [31:0]    rd;
    off  = 1'b0;
    test = 1'b0;
    el   = '0;
    rd   = '0;
    st_next = st_reg;

    // Program-cycle divider; comparators update on tick, core one cycle later
    st_next.tick = 1'b0;
    st_next.eval = st_reg.tick;
    if (st_reg.div == DIV_LAST) begin
      st_next.div  = '0;
      st_next.tick = 1'b1; // [R26]
    end else begin
      st_next.div = st_reg.div + 1'b1;
    end

    // Sampled only on tick, so a late block misses the current cycle
    if (st_reg.tick) begin
      st_next.blk_s = i_block ||
                      (st_reg.ln == cbf_pkg::CBF_LN_BLOCKED) ||
                      (st_reg.ln == cbf_pkg::CBF_LN_TEST_BLK); // [R9] [R13]
    end

    // Settings take effect at the next evaluation, no restart needed
    if (i_wr) begin
      case (i_addr)
        cbf_pkg::A_CTRL: begin
          st_next.mode    = cbf_pkg::cbf_mode_e'(i_wdata[cbf_pkg::CTRL_MODE_LSB +: 4]); // [R21]
          st_next.res_sel = cbf_pkg::cbf_res_e'(i_wdata[cbf_pkg::CTRL_RES_LSB +: 2]);
          st_next.rt_en   = i_wdata[cbf_pkg::CTRL_RT_BIT];
          st_next.ln      = cbf_pkg::cbf_ln_e'(i_wdata[cbf_pkg::CTRL_LN_LSB +: 3]);
        end
        cbf_pkg::A_PH_THR:  st_next.ph_thr   = i_wdata[MW-1:0]; // [R21]
        cbf_pkg::A_RES_THR: st_next.res_thr  = i_wdata[MW-1:0];
        cbf_pkg::A_RT_DLY:  st_next.rt_dly   = i_wdata[DW-1:0];
        cbf_pkg::A_BF_DLY:  st_next.bf_dly   = i_wdata[DW-1:0];
        cbf_pkg::A_SIG_MSK: st_next.sig_mask = i_wdata[P_N_SIG-1:0];
        cbf_pkg::A_DO_MSK:  st_next.do_mask  = i_wdata[P_N_DO-1:0];
        default: ;
      endcase
    end

    // Evaluation once per program cycle
    off  = (st_reg.ln == cbf_pkg::CBF_LN_OFF);
    test = (st_reg.ln == cbf_pkg::CBF_LN_TEST) || (st_reg.ln == cbf_pkg::CBF_LN_TEST_BLK);
    if (st_reg.eval) begin
      if (off || !crit) begin
        st_next.start   = 1'b0; // [R4] [R23]
        st_next.blocked = 1'b0;
        st_next.elapsed = '0;
        st_next.retrip  = 1'b0;
        st_next.fail    = 1'b0;
        // Current seen but mode still waiting on its other criterion
        st_next.cond    = (cur_hit && !off) ? cbf_pkg::CBF_C_ON : cbf_pkg::CBF_C_NORMAL; // [R19] [R24]
      end else if (st_reg.blk_s) begin
        st_next.start   = 1'b0; // [R11] [R12]
        st_next.blocked = 1'b1; // [R11]
        st_next.elapsed = '0; // [R12]
        st_next.retrip  = 1'b0;
        st_next.fail    = 1'b0;
        st_next.cond    = cbf_pkg::CBF_C_BLOCKED; // [R19]
      end else begin
        // Saturate so a long standing fault cannot wrap the timer
        if (!st_reg.start) begin
          el = '0; // [R10] [R14]
        end else if (st_reg.elapsed != '1) begin
          el = st_reg.elapsed + 1'b1; // [R26]
        end else begin
          el = st_reg.elapsed;
        end
        st_next.elapsed = el;
        st_next.start   = 1'b1; // [R10]
        st_next.blocked = 1'b0;
        // Test mode shows the condition but keeps the contacts open
        st_next.retrip  = st_reg.rt_en && (el >= st_reg.rt_dly) && !test; // [R16] [R17]
        st_next.fail    = (el >= st_reg.bf_dly) && !test; // [R18]
        if (el >= st_reg.bf_dly) begin
          st_next.cond = cbf_pkg::CBF_C_FAIL; // [R19]
        end else if (st_reg.rt_en && (el >= st_reg.rt_dly)) begin
          st_next.cond = cbf_pkg::CBF_C_RETRIP;
        end else begin
          st_next.cond = cbf_pkg::CBF_C_START;
        end
      end
    end

    // Read port: data valid the cycle after the strobe only
    if (i_rd) begin
      case (i_addr)
        cbf_pkg::A_CTRL: begin
          rd[cbf_pkg::CTRL_MODE_LSB +: 4] = st_reg.mode;
          rd[cbf_pkg::CTRL_RES_LSB +: 2]  = st_reg.res_sel;
          rd[cbf_pkg::CTRL_RT_BIT]        = st_reg.rt_en;
          rd[cbf_pkg::CTRL_LN_LSB +: 3]   = st_reg.ln;
        end
        cbf_pkg::A_PH_THR:  rd[MW-1:0]      = st_reg.ph_thr;
        cbf_pkg::A_RES_THR: rd[MW-1:0]      = st_reg.res_thr;
        cbf_pkg::A_RT_DLY:  rd[DW-1:0]      = st_reg.rt_dly;
        cbf_pkg::A_BF_DLY:  rd[DW-1:0]      = st_reg.bf_dly;
        cbf_pkg::A_SIG_MSK: rd[P_N_SIG-1:0] = st_reg.sig_mask;
        cbf_pkg::A_DO_MSK:  rd[P_N_DO-1:0]  = st_reg.do_mask;
        cbf_pkg::A_STATUS: begin
          rd[cbf_pkg::ST_COND_LSB +: 3]  = st_reg.cond; // [R19]
          rd[cbf_pkg::ST_LN_LSB +: 3]    = st_reg.ln; // [R20]
          rd[cbf_pkg::ST_START_BIT]      = st_reg.start;
          rd[cbf_pkg::ST_BLK_BIT]        = st_reg.blocked;
          rd[cbf_pkg::ST_RT_BIT]         = st_reg.retrip;
          rd[cbf_pkg::ST_BF_BIT]         = st_reg.fail;
          rd[cbf_pkg::ST_PICK_LSB +: 4]  = pif.pick;
        end
        default: rd = '0;
      endcase
    end
    st_next.rdata = rd;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata                  = st_reg.rdata;
  assign o_start                  = st_reg.start;
  assign o_blocked                = st_reg.blocked;
  assign o_retrip                 = st_reg.retrip;
  assign o_breaker_failure_output = st_reg.fail;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  a_block_sample: assert property (!st_reg.tick |=> $stable(st_reg.blk_s)) // [R9]
    else $error("blocking sample moved outside a program tick");

  a_start_raise: assert property ( // [R10]
    st_reg.eval && crit && !st_reg.blk_s && st_reg.ln == cbf_pkg::CBF_LN_ON
    |=> o_start && !o_blocked)
    else $error("start not raised on unblocked pick-up");

  a_block_flag: assert property ( // [R11]
    st_reg.eval && crit && st_reg.blk_s && st_reg.ln != cbf_pkg::CBF_LN_OFF
    |=> o_blocked && !o_start && !o_retrip && !o_breaker_failure_output && st_reg.elapsed == '0)
    else $error("blocked pick-up was processed further");

  a_drop_reset: assert property ( // [R23]
    st_reg.eval && !crit |=> !o_start && st_reg.elapsed == '0 && !o_retrip && !o_breaker_failure_output)
    else $error("timers not reset after pick-up dropped");

  a_retrip_time: assert property ( // [R17]
    $rose(o_retrip) |-> st_reg.start && st_reg.elapsed >= st_reg.rt_dly && $past(st_reg.eval))
    else $error("retrip raised before its delay");

  a_fail_time: assert property ( // [R18]
    $rose(o_breaker_failure_output) |-> st_reg.start && st_reg.elapsed >= st_reg.bf_dly)
    else $error("breaker failure output raised before its delay");

  a_retrip_off: assert property (!st_reg.rt_en && st_reg.eval |=> !o_retrip) // [R16]
    else $error("retrip output while retrip is disabled");

  a_and_halt: assert property ( // [R24]
    st_reg.eval && st_reg.mode == cbf_pkg::CBF_M_CUR_AND_DO && !do_hit
    |=> !o_start && st_reg.elapsed == '0)
    else $error("timer ran before the monitored relay was driven");

  a_or_count: assert property ( // [R25]
    st_reg.eval && st_reg.mode == cbf_pkg::CBF_M_CUR_OR_DO && do_hit && !st_reg.blk_s &&
    st_reg.ln == cbf_pkg::CBF_LN_ON
    |=> o_start)
    else $error("relay alone did not start counting in current or relay mode");

  a_test_quiet: assert property ( // [R20]
    st_reg.eval && (st_reg.ln == cbf_pkg::CBF_LN_TEST || st_reg.ln == cbf_pkg::CBF_LN_TEST_BLK)
    |=> !o_retrip && !o_breaker_failure_output)
    else $error("contact closed in test behaviour");

  a_off_clear: assert property ( // [R20]
    st_reg.eval && st_reg.ln == cbf_pkg::CBF_LN_OFF |=> !o_start && !o_blocked && !o_retrip)
    else $error("output active while the block is off");

  a_start_zero: assert property ($rose(o_start) |-> st_reg.elapsed == '0) // [R14]
    else $error("shared timer not restarted with start");

  a_block_restart: assert property ( // [R12]
    st_reg.eval && st_reg.start && crit && st_reg.blk_s |=> !o_start && st_reg.elapsed == '0)
    else $error("start kept after blocking arrived");

  a_fail_cond: assert property (o_breaker_failure_output |-> st_reg.cond == cbf_pkg::CBF_C_FAIL) // [R19]
    else $error("failure output without failure condition");
endmodule
`default_nettype wire

// File: cbf_top_tb.sv
// Self-checking testbench of the breaker-failure protection block
`default_nettype none
module cbf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             i_mclk = 0, i_nrst = 0, wr = 0, rd = 0, blk = 0, stuck = 1;
  logic [7:0]       addr = 8'h00, rel = 8'h00;
  logic [31:0]      wdata = 32'h0000_0000, v, rdata;
  logic [2:0][15:0] mag = '0;
  logic [15:0]      res1 = 16'h0000, sig = 16'h0000;
  logic             st, bk, rt, bf, opn;
  int               fail_count = 0, cmp_count = 0, cyc = 0, n;
  always #2 i_mclk = ~i_mclk;
  cbf_top #(.P_TICK_CYCLES(8)) dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_measured_magnitude(mag), .i_residual_input_one(res1),
    .i_residual_input_two(16'h0000), .i_calculated_residual(16'h0000), .i_block(blk),
    .i_trip_events(sig), .i_relay_state(rel), .o_start(st), .o_blocked(bk), .o_retrip(rt),
    .o_breaker_failure_output(bf));
  cbf_breaker_model #(.P_OP_CYCLES(4)) brk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_stuck(stuck),
    .i_retrip(rt), .o_open(opn));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d of %0d comparisons", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs under 2000 cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr_r(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk); addr <= a; wdata <= d; wr <= 1;
    @(posedge i_mclk); wr <= 0;
  endtask
  task automatic rd_r(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk); addr <= a; rd <= 1;
    @(posedge i_mclk); rd <= 0;
    #1 d = rdata;
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic setm(input int p, input logic [15:0] m);
    @(posedge i_mclk); mag[p] <= m;
  endtask
  function automatic logic sel(input int s);
    case (s)
      0: return st;
      1: return rt;
      2: return bf;
      default: return opn;
    endcase
  endfunction
  // Counts edges until the chosen output is high; bounded
  task automatic wait_on(input int s);
    n = 0;
    do begin
      @(posedge i_mclk); #1; n++;
    end while (sel(s) !== 1'b1 && n < 300);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    rd_r(cbf_pkg::A_CTRL, v); chk(v, 32'h0000_0040);
    rd_r(cbf_pkg::A_PH_THR, v); chk(v, 32'h0000_0014);
    rd_r(cbf_pkg::A_RES_THR, v); chk(v, 32'h0000_04B0);
    rd_r(cbf_pkg::A_RT_DLY, v); chk(v, 32'h0000_0014);
    rd_r(cbf_pkg::A_BF_DLY, v); chk(v, 32'h0000_0028);
    rd_r(8'h20, v); chk(v, 32'h0000_0000);
  endtask
  task automatic s_pick();
    wr_r(cbf_pkg::A_RT_DLY, 32'h0000_0002);
    wr_r(cbf_pkg::A_BF_DLY, 32'h0000_0004);
    setm(1, 16'h0014); cyc_n(40); chk(st, 1'b0);
    setm(1, 16'h0015); wait_on(0); chk(st, 1'b1);
    wait_on(1); chk(32'(n), 32'h0000_0010);
    wait_on(2); chk(32'(n), 32'h0000_0010);
    setm(1, 16'h0014); cyc_n(24); chk(st, 1'b1);
    setm(1, 16'h0013); cyc_n(24); chk({st, rt, bf}, 3'b000);
  endtask
  task automatic s_clear();
    @(posedge i_mclk); stuck <= 0;
    // Failure delay longer than retrip plus breaker and release time
    wr_r(cbf_pkg::A_BF_DLY, 32'h0000_0008);
    setm(0, 16'h0032); wait_on(3); chk(opn, 1'b1);
    setm(0, 16'h0000); cyc_n(80); chk({st, bf}, 2'b00);
  endtask
  task automatic s_block();
    setm(2, 16'h001E); wait_on(0);
    // Block lands well ahead of the retrip delay
    @(posedge i_mclk); blk <= 1;
    cyc_n(24); chk({st, bk, rt}, 3'b010);
    setm(2, 16'h0000); blk <= 0; cyc_n(24); chk(bk, 1'b0);
  endtask
  task automatic s_and_do();
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0043); wr_r(cbf_pkg::A_DO_MSK, 32'h0000_0001);
    setm(0, 16'h001E); cyc_n(40); chk(st, 1'b0);
    rd_r(cbf_pkg::A_STATUS, v); chk(v[6:0], 7'h04);
    @(posedge i_mclk); rel <= 8'h01;
    wait_on(0); chk(st, 1'b1);
    setm(0, 16'h0000); rel <= 8'h00; cyc_n(24);
  endtask
  task automatic s_residual();
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0050);
    @(posedge i_mclk); res1 <= 16'h04B0; cyc_n(24); chk(st, 1'b0);
    @(posedge i_mclk); res1 <= 16'h04B1; wait_on(0); chk(st, 1'b1);
    rd_r(cbf_pkg::A_STATUS, v); chk(v[15:12], 4'h8);
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0040); cyc_n(24); chk(st, 1'b0);
    @(posedge i_mclk); res1 <= 16'h0000;
  endtask
  task automatic s_signal();
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0042); wr_r(cbf_pkg::A_SIG_MSK, 32'h0000_0008);
    @(posedge i_mclk); sig <= 16'h0004; cyc_n(24); chk(st, 1'b0);
    @(posedge i_mclk); sig <= 16'h0008; wait_on(0); chk(st, 1'b1);
    @(posedge i_mclk); sig <= 16'h0000; cyc_n(24); chk(st, 1'b0);
  endtask
  task automatic s_test();
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0240); setm(0, 16'h001E); wait_on(0);
    cyc_n(40); chk({rt, bf}, 2'b00);
    rd_r(cbf_pkg::A_STATUS, v); chk(v[6:0], 7'h22);
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0440); cyc_n(24); chk(st, 1'b0);
    setm(0, 16'h0000);
  endtask
  task automatic s_rt_off();
    wr_r(cbf_pkg::A_CTRL, 32'h0000_0000);
    setm(0, 16'h001E); wait_on(2); chk({rt, bf}, 2'b01);
    setm(0, 16'h0000); cyc_n(24); chk(bf, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1;
    s_reset();
    s_pick();
    s_clear();
    s_block();
    s_and_do();
    s_residual();
    s_signal();
    s_test();
    s_rt_off();
    results();
  end
endmodule
`default_nettype wire
